// *** bfs_map.svh ***
// Address map, field positions, codes and timing constants of the bank
`ifndef BFS_MAP_SVH
`define BFS_MAP_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define BFS_ADDR_STATUS 8'h01
`define BFS_ADDR_TRIM_ONE 8'h3e
`define BFS_ADDR_TRIM_TWO 8'h3f

// ------------------------------------------------------------
// Status word bit positions
// ------------------------------------------------------------
`define BFS_ST_PGOOD_N 8
`define BFS_ST_OVP 7
`define BFS_ST_PIN_FAULT 6
`define BFS_ST_OCP2 4
`define BFS_ST_OCP1 3
`define BFS_ST_PEAK2 2
`define BFS_ST_PEAK1 1
`define BFS_PARITY_BIT 0

// ------------------------------------------------------------
// Trimming word layout and operation codes
// ------------------------------------------------------------
`define BFS_OPC_HI 23
`define BFS_OPC_LO 21
`define BFS_FIELD_HI 20
`define BFS_FIELD_LO 5
`define BFS_TRIM_DONE_BIT 5
`define BFS_OPC_RESET 3'h0
`define BFS_OPC_STD_READ 3'h1
`define BFS_OPC_MARGIN_READ 3'h2
`define BFS_OPC_BLANK_CHECK 3'h3
`define BFS_OPC_BURN 3'h4
`define BFS_OPC_END_TRIM 3'h7
`define BFS_FIELD_RESET 16'h0000
`define BFS_WORD_ZERO 24'h000000

// ------------------------------------------------------------
// Switching-cycle counts and times
// ------------------------------------------------------------
`define BFS_MISS_LIMIT 2'h3
`define BFS_PEAK_LIMIT 4'ha
`define BFS_CLK_MHZ 100
`define BFS_OCP_FILTER_US 2000
`define BFS_AUTO_RESTART_US 1000

`endif

// *** bfs_pkg.sv ***
// Shared types of the boost fault, status and trimming bank
package bfs_pkg;
    typedef logic [23:0] bfs_word_t;
    typedef logic [2:0] bfs_opcode_t;
    typedef logic [15:0] bfs_field_t;
endpackage : bfs_pkg

// *** bfs_phase_monitor.sv ***
// Per-phase overcurrent filter and peak comparator timeout
`timescale 1ns/1ps
`include "bfs_map.svh"

module bfs_phase_monitor import bfs_pkg::*; #(
    parameter int unsigned FILTER_CYCLES = 200000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Synchronised phase events
    input wire logic cycle_tick,
    input wire logic limit_hit,
    input wire logic peak_reach,
    // Results
    output logic ocp_expired,
    output logic peak_timeout
);
    logic hit_seen;
    logic reach_seen;
    logic oc_flag;
    logic [1:0] miss_cnt;
    logic [31:0] filt_cnt;
    logic [3:0] nreach_cnt;
    logic [3:0] reach_cnt;
    logic hit_now;
    logic reach_now;

    assign hit_now = hit_seen | limit_hit;
    assign reach_now = reach_seen | peak_reach;

    // ------------------------------------------------------------
    // Per-cycle capture, restarted on each switching cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst || cycle_tick) begin
            hit_seen <= 1'b0;
            reach_seen <= 1'b0;
        end else begin
            hit_seen <= hit_now;
            reach_seen <= reach_now;
        end
    end

    // Internal flag: first hit sets, three clean cycles drop it
    always_ff @(posedge clk) begin
        if (srst) begin
            oc_flag <= 1'b0;
            miss_cnt <= 2'h0;
        end else if (cycle_tick) begin
            if (hit_now) begin
                oc_flag <= 1'b1;
                miss_cnt <= 2'h0;
            end else if (oc_flag) begin
                if (miss_cnt == `BFS_MISS_LIMIT - 2'h1) begin
                    oc_flag <= 1'b0;
                    miss_cnt <= 2'h0;
                end else begin
                    miss_cnt <= miss_cnt + 2'h1;
                end
            end
        end else if (limit_hit) begin
            oc_flag <= 1'b1;
        end
    end

    // Filter time: flag still up when the count runs out
    always_ff @(posedge clk) begin
        if (srst || !oc_flag) begin
            filt_cnt <= 32'h0;
            ocp_expired <= 1'b0;
        end else if (filt_cnt == FILTER_CYCLES - 1) begin
            ocp_expired <= 1'b1;
        end else begin
            filt_cnt <= filt_cnt + 32'h1;
        end
    end

    // Peak level timeout with ten-cycle hysteresis both ways
    always_ff @(posedge clk) begin
        if (srst) begin
            nreach_cnt <= 4'h0;
            reach_cnt <= 4'h0;
            peak_timeout <= 1'b0;
        end else if (cycle_tick) begin
            if (reach_now) begin
                nreach_cnt <= 4'h0;
                if (reach_cnt == `BFS_PEAK_LIMIT - 4'h1) begin
                    peak_timeout <= 1'b0;
                end else begin
                    reach_cnt <= reach_cnt + 4'h1;
                end
            end else begin
                reach_cnt <= 4'h0;
                if (nreach_cnt == `BFS_PEAK_LIMIT - 4'h1) begin
                    peak_timeout <= 1'b1;
                end else begin
                    nreach_cnt <= nreach_cnt + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_flag_drop_tick: assert property (
        $fell(oc_flag) |-> $past(cycle_tick) && $past(miss_cnt) == 2'h2)
        else $error("Overcurrent flag dropped off a cycle boundary");
    chk_timeout_rise: assert property (
        $rose(peak_timeout) |-> $past(nreach_cnt) == 4'h9)
        else $error("Peak timeout set before ten missed cycles");
    chk_expire_needs_flag: assert property (
        ocp_expired |-> $past(oc_flag))
        else $error("Overcurrent expiry without internal flag");
endmodule : bfs_phase_monitor

// *** bfs_regs.sv ***
// Boost fault status and customer trimming register bank
`timescale 1ns/1ps
`include "bfs_map.svh"

module bfs_regs import bfs_pkg::*; #(
    parameter int unsigned OCP_FILTER_CYCLES =
        `BFS_OCP_FILTER_US * `BFS_CLK_MHZ,
    parameter int unsigned AUTO_RESTART_CYCLES =
        `BFS_AUTO_RESTART_US * `BFS_CLK_MHZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register word access from the serial frame logic
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic acc_clear,
    input wire logic [7:0] acc_addr,
    input wire bfs_word_t acc_wdata,
    output bfs_word_t acc_rdata,
    output logic acc_ack,
    output logic acc_err,
    // Operating mode
    input wire logic normal_mode,
    input wire logic fallback_mode,
    input wire logic boost_disable,
    // Analogue comparator levels, asynchronous
    input wire logic out_pin_bad_raw,
    input wire logic ph1_cycle_raw,
    input wire logic ph2_cycle_raw,
    input wire logic ph1_limit_raw,
    input wire logic ph2_limit_raw,
    input wire logic ph1_peak_raw,
    input wire logic ph2_peak_raw,
    input wire logic pgood_n_raw,
    input wire logic ovp_raw,
    // Boost control
    output logic boost_allow,
    output logic phase_sync_en,
    output logic comp_pull_low,
    // Trimming contents
    output bfs_opcode_t trim_opcode,
    output bfs_field_t trim_fields_one,
    output bfs_field_t trim_fields_two
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic odd_parity(input bfs_word_t w);
        odd_parity = ~(^w[23:1]);
    endfunction : odd_parity

    function automatic logic word_ok(input bfs_word_t w);
        word_ok = ^w;
    endfunction : word_ok

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [8:0] sync1;
    logic [8:0] sync2;
    logic [1:0] cyc3;
    logic s_pin_bad;
    logic s_cyc1;
    logic s_cyc2;
    logic s_lim1;
    logic s_lim2;
    logic s_peak1;
    logic s_peak2;
    logic s_pgood_n;
    logic s_ovp;

    // Two flops per level; cycle pulses take one more for the edge
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1 <= 9'h000;
            sync2 <= 9'h000;
            cyc3 <= 2'h0;
        end else begin
            sync1 <= {out_pin_bad_raw, ph1_cycle_raw, ph2_cycle_raw,
                      ph1_limit_raw, ph2_limit_raw, ph1_peak_raw,
                      ph2_peak_raw, pgood_n_raw, ovp_raw};
            sync2 <= sync1;
            cyc3 <= {s_cyc1, s_cyc2};
        end
    end

    assign {s_pin_bad, s_cyc1, s_cyc2, s_lim1, s_lim2, s_peak1, s_peak2,
            s_pgood_n, s_ovp} = sync2;

    // ------------------------------------------------------------
    // Phase monitors
    // ------------------------------------------------------------
    logic tick1;
    logic tick2;
    logic ocp_exp1;
    logic ocp_exp2;
    logic peak_to1;
    logic peak_to2;

    assign tick1 = s_cyc1 & ~cyc3[1];
    assign tick2 = s_cyc2 & ~cyc3[0];

    bfs_phase_monitor #(.FILTER_CYCLES(OCP_FILTER_CYCLES)) u_ph1 (
        .clk(clk),
        .srst(srst),
        .cycle_tick(tick1),
        .limit_hit(s_lim1),
        .peak_reach(s_peak1),
        .ocp_expired(ocp_exp1),
        .peak_timeout(peak_to1)
    );

    bfs_phase_monitor #(.FILTER_CYCLES(OCP_FILTER_CYCLES)) u_ph2 (
        .clk(clk),
        .srst(srst),
        .cycle_tick(tick2),
        .limit_hit(s_lim2),
        .peak_reach(s_peak2),
        .ocp_expired(ocp_exp2),
        .peak_timeout(peak_to2)
    );

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic hit_status;
    logic hit_trim;
    logic trim_gate;
    logic bad_parity;
    logic refuse;
    logic rc_clear;
    logic auto_clear;

    assign hit_status = acc_addr == `BFS_ADDR_STATUS;
    assign hit_trim = acc_addr == `BFS_ADDR_TRIM_ONE ||
                      acc_addr == `BFS_ADDR_TRIM_TWO;
    // Writes carry the burn code themselves, reads use the stored one
    assign trim_gate = normal_mode && !trim_fields_two[0] &&
        (acc_write ? acc_wdata[`BFS_OPC_HI:`BFS_OPC_LO] == `BFS_OPC_BURN
                   : trim_opcode == `BFS_OPC_BURN);
    assign bad_parity = acc_write && !word_ok(acc_wdata);
    assign refuse = bad_parity || !(hit_status || hit_trim) ||
                    (hit_trim && !trim_gate) ||
                    (hit_status && acc_write);
    assign rc_clear = acc_valid && acc_clear && hit_status && !refuse;

    // ------------------------------------------------------------
    // Output pin fault and auto restart
    // ------------------------------------------------------------
    logic pin_fault;
    logic next_pin_fault;
    logic [31:0] restart_cnt;

    // Set wins over any clear so a fault present at clear time stays
    assign next_pin_fault = (s_pin_bad && !boost_disable) ? 1'b1 :
        (rc_clear || auto_clear) ? 1'b0 : pin_fault;
    assign auto_clear = fallback_mode &&
                        restart_cnt == AUTO_RESTART_CYCLES - 1;

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_fault <= 1'b0;
            boost_allow <= 1'b0;
            phase_sync_en <= 1'b0;
            comp_pull_low <= 1'b0;
        end else begin
            pin_fault <= next_pin_fault;
            boost_allow <= !next_pin_fault;
            phase_sync_en <= !next_pin_fault;
            comp_pull_low <= fallback_mode && next_pin_fault;
        end
    end

    // Free-running restart period, only while in fallback mode
    always_ff @(posedge clk) begin
        if (srst || !fallback_mode || auto_clear) begin
            restart_cnt <= 32'h0;
        end else begin
            restart_cnt <= restart_cnt + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Latched and real-time status bits
    // ------------------------------------------------------------
    logic ocp1;
    logic ocp2;
    logic pgood_n;
    logic ovp;

    always_ff @(posedge clk) begin
        if (srst) begin
            ocp1 <= 1'b0;
            ocp2 <= 1'b0;
            pgood_n <= 1'b0;
            ovp <= 1'b0;
        end else begin
            ocp1 <= ocp_exp1 ? 1'b1 : (rc_clear ? 1'b0 : ocp1);
            ocp2 <= ocp_exp2 ? 1'b1 : (rc_clear ? 1'b0 : ocp2);
            pgood_n <= s_pgood_n && !boost_disable;
            ovp <= s_ovp && !boost_disable && !pin_fault;
        end
    end

    // ------------------------------------------------------------
    // Trimming registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            trim_opcode <= `BFS_OPC_RESET;
            trim_fields_one <= `BFS_FIELD_RESET;
            trim_fields_two <= `BFS_FIELD_RESET;
        end else if (acc_valid && acc_write && !refuse) begin
            trim_opcode <= acc_wdata[`BFS_OPC_HI:`BFS_OPC_LO];
            if (acc_addr == `BFS_ADDR_TRIM_ONE) begin
                // Bits 4..1 are dropped here
                trim_fields_one <=
                    acc_wdata[`BFS_FIELD_HI:`BFS_FIELD_LO];
            end else begin
                trim_fields_two <=
                    acc_wdata[`BFS_FIELD_HI:`BFS_FIELD_LO];
            end
        end
    end

    // ------------------------------------------------------------
    // Read word assembly and answer
    // ------------------------------------------------------------
    bfs_word_t rd_word;

    always_comb begin
        rd_word = `BFS_WORD_ZERO;
        if (hit_status) begin
            rd_word[`BFS_ST_PGOOD_N] = pgood_n;
            rd_word[`BFS_ST_OVP] = ovp;
            rd_word[`BFS_ST_PIN_FAULT] = pin_fault;
            rd_word[`BFS_ST_OCP2] = ocp2;
            rd_word[`BFS_ST_OCP1] = ocp1;
            rd_word[`BFS_ST_PEAK2] = peak_to2;
            rd_word[`BFS_ST_PEAK1] = peak_to1;
        end else begin
            rd_word[`BFS_OPC_HI:`BFS_OPC_LO] = trim_opcode;
            rd_word[`BFS_FIELD_HI:`BFS_FIELD_LO] =
                (acc_addr == `BFS_ADDR_TRIM_ONE) ? trim_fields_one
                                                 : trim_fields_two;
        end
        rd_word[`BFS_PARITY_BIT] = odd_parity(rd_word);
    end

    // One answer per request, the cycle after it is taken
    always_ff @(posedge clk) begin
        if (srst) begin
            acc_ack <= 1'b0;
            acc_err <= 1'b0;
            acc_rdata <= `BFS_WORD_ZERO;
        end else begin
            acc_ack <= acc_valid;
            acc_err <= acc_valid && refuse;
            acc_rdata <= (acc_valid && !refuse && !acc_write) ?
                         rd_word : `BFS_WORD_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_trim_req_outside;
        acc_valid && hit_trim && !normal_mode;
    endsequence
    sequence s_refused_answer;
        acc_ack && acc_err && acc_rdata == `BFS_WORD_ZERO;
    endsequence

    chk_fault_stops_boost: assert property (
        pin_fault |-> !boost_allow)
        else $error("Boost allowed while pin fault set");
    chk_fault_no_sync: assert property (
        $rose(pin_fault) |-> !phase_sync_en ##1 !phase_sync_en || !pin_fault)
        else $error("Sync clock enabled during pin fault");
    chk_comp_pulldown: assert property (
        comp_pull_low |-> pin_fault && $past(fallback_mode))
        else $error("Compensation pulled low without cause");
    chk_fault_disable_gate: assert property (
        $rose(pin_fault) |-> !$past(boost_disable))
        else $error("Pin fault set while boost disabled");
    chk_fault_clear_cause: assert property (
        $fell(pin_fault) |-> $past(rc_clear) || $past(auto_clear))
        else $error("Pin fault cleared without read-clear or restart");
    chk_ocp_sticky: assert property (
        $fell(ocp1) || $fell(ocp2) |-> $past(rc_clear))
        else $error("Overcurrent status dropped without read-clear");
    chk_answer_parity: assert property (
        acc_ack && !acc_err && !$past(acc_write) |-> ^acc_rdata)
        else $error("Read word without odd parity");
    chk_trim_guard: assert property (
        s_trim_req_outside |=> s_refused_answer)
        else $error("Trim access outside normal mode not refused");
    chk_opcode_reset: assert property (
        $past(srst) |-> trim_opcode == `BFS_OPC_RESET)
        else $error("Trim opcode not cleared by reset");
    chk_disable_gates_status: assert property (
        pgood_n || ovp |-> !$past(boost_disable))
        else $error("Status bit set while boost disabled");
endmodule : bfs_regs

// *** bfs_host_model.sv ***
// Host controller model issuing register word requests to the bank
`timescale 1ns/1ps

module bfs_host_model import bfs_pkg::*; (
    // Clock
    input wire logic clk,
    // Request side
    output logic acc_valid,
    output logic acc_write,
    output logic acc_clear,
    output logic [7:0] acc_addr,
    output bfs_word_t acc_wdata,
    // Answer side
    input wire bfs_word_t acc_rdata,
    input wire logic acc_ack
);
    // Idle at time zero, no request until the bench asks
    initial begin
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_clear = 1'b0;
        acc_addr = 8'h00;
        acc_wdata = 24'h000000;
    end

    // One strobe cycle, then a bounded wait for the answer; bad_par flips
    // the parity bit so that the bank's refusal can be seen
    task automatic access(input logic wr, input logic clr,
            input logic [7:0] addr, input bfs_word_t data,
            input logic bad_par, output bfs_word_t rd, output logic ok);
        bfs_word_t w;
        w = {data[23:1], ~^data[23:1]};
        w[0] = w[0] ^ bad_par;
        ok = 1'b0;
        rd = 24'h000000;
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_write <= wr;
        acc_clear <= clr;
        acc_addr <= addr;
        acc_wdata <= w;
        @(posedge clk);
        acc_valid <= 1'b0;
        // Released lines carry the inverse so stale data never looks valid
        acc_wdata <= ~w;
        acc_addr <= ~addr;
        for (int i = 0; i < 3 && !ok; i++) begin
            @(posedge clk);
            if (acc_ack === 1'b1) begin
                ok = 1'b1;
                rd = acc_rdata;
            end
        end
    endtask : access
endmodule : bfs_host_model

// *** bfs_regs_tb.sv ***
// Self-checking bench for the fault status and trimming register bank
`timescale 1ns/1ps
`include "bfs_map.svh"

`define CHK(nm, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("mismatch %s expected %h seen %h", nm, exp, got); \
        end \
    end

module bfs_regs_tb import bfs_pkg::*;;
    localparam int FILT = 40;
    localparam int AUTO = 30;
    typedef struct {bfs_word_t rd; logic err;} bfs_note_s;
    logic clk, srst, acc_valid, acc_write, acc_clear, acc_ack, acc_err;
    logic [7:0] acc_addr;
    bfs_word_t acc_wdata, acc_rdata;
    logic normal_mode, fallback_mode, boost_disable, out_pin_bad_raw;
    logic ph1_cycle_raw, ph2_cycle_raw, ph1_limit_raw, ph2_limit_raw;
    logic ph1_peak_raw, ph2_peak_raw, pgood_n_raw, ovp_raw;
    logic boost_allow, phase_sync_en, comp_pull_low;
    bfs_opcode_t trim_opcode;
    bfs_field_t trim_fields_one, trim_fields_two;
    bfs_note_s notes[$];
    bfs_note_s note;
    int errors = 0;
    int check_count = 0;
    logic [31:0] seed = 32'h00011cc0;

    bfs_regs #(.OCP_FILTER_CYCLES(FILT), .AUTO_RESTART_CYCLES(AUTO)) DUT (
        .clk(clk), .srst(srst), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_clear(acc_clear), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_ack(acc_ack),
        .acc_err(acc_err), .normal_mode(normal_mode),
        .fallback_mode(fallback_mode), .boost_disable(boost_disable),
        .out_pin_bad_raw(out_pin_bad_raw), .ph1_cycle_raw(ph1_cycle_raw),
        .ph2_cycle_raw(ph2_cycle_raw), .ph1_limit_raw(ph1_limit_raw),
        .ph2_limit_raw(ph2_limit_raw), .ph1_peak_raw(ph1_peak_raw),
        .ph2_peak_raw(ph2_peak_raw), .pgood_n_raw(pgood_n_raw),
        .ovp_raw(ovp_raw), .boost_allow(boost_allow),
        .phase_sync_en(phase_sync_en), .comp_pull_low(comp_pull_low),
        .trim_opcode(trim_opcode), .trim_fields_one(trim_fields_one),
        .trim_fields_two(trim_fields_two));

    bfs_host_model host (
        .clk(clk), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_clear(acc_clear), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_rdata(acc_rdata), .acc_ack(acc_ack));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Expected read word with odd parity in bit 0
    function automatic bfs_word_t par(input bfs_word_t w);
        return {w[23:1], ~^w[23:1]};
    endfunction : par

    // Write word with junk in the reserved bits, which must be dropped
    function automatic bfs_word_t wd(input bfs_opcode_t o, bfs_field_t f);
        return {o, f, 4'hf, 1'b0};
    endfunction : wd

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    // Notes the expected answer, then lets the host make the request
    task automatic req(input logic wr, clr, input logic [7:0] a,
            input bfs_word_t d, input logic bad, input bfs_word_t er,
            input logic ee);
        bfs_word_t rd;
        logic ok;
        notes.push_back('{er, ee});
        host.access(wr, clr, a, d, bad, rd, ok);
        if (!ok) begin
            errors++;
            $display("mismatch acc_ack expected 1 seen 0");
            summarize();
        end
    endtask : req

    task automatic st(input logic clr, input bfs_word_t e);
        req(1'b0, clr, `BFS_ADDR_STATUS, 24'h0, 1'b0, par(e), 1'b0);
    endtask : st

    // Bounded wait for the boost permission to reach a level
    task automatic wait_allow(input logic v, input int n);
        for (int i = 0; i < n && boost_allow !== v; i++) begin
            @(posedge clk);
        end
        `CHK("boost_allow", v, boost_allow)
        if (boost_allow !== v) summarize();
    endtask : wait_allow

    // Switching cycles of four clocks with limit and peak levels held
    task automatic cyc(input int ph, input logic lim, pk, input int n);
        repeat (n) begin
            @(posedge clk);
            if (ph == 1) begin
                ph1_limit_raw <= lim;
                ph1_peak_raw <= pk;
                ph1_cycle_raw <= 1'b1;
            end else begin
                ph2_limit_raw <= lim;
                ph2_peak_raw <= pk;
                ph2_cycle_raw <= 1'b1;
            end
            repeat (2) @(posedge clk);
            ph1_cycle_raw <= 1'b0;
            ph2_cycle_raw <= 1'b0;
            @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask : cyc

    // Answer watcher: every acknowledge consumes the oldest note
    always @(posedge clk) begin
        if (acc_ack === 1'b1) begin
            if (notes.size() == 0) begin
                errors++;
                $display("mismatch acc_ack expected 0 seen 1");
            end else begin
                note = notes.pop_front();
                `CHK("acc_rdata", note.rd, acc_rdata)
                `CHK("acc_err", note.err, acc_err)
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        bfs_field_t f1;
        bfs_field_t f2;
        srst = 1'b1;
        {normal_mode, fallback_mode, boost_disable, out_pin_bad_raw} = 4'h0;
        {ph1_cycle_raw, ph2_cycle_raw, ph1_limit_raw, ph2_limit_raw} = 4'h0;
        {ph1_peak_raw, ph2_peak_raw, pgood_n_raw, ovp_raw} = 4'hc;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        seed = lfsr(lfsr(seed));
        f1 = seed[15:0];
        seed = lfsr(lfsr(seed));
        f2 = {seed[15:1], 1'b0};
        // Trimming gate, codes, parity and layout
        req(1, 0, `BFS_ADDR_TRIM_ONE, wd(3'h4, f1), 0, 0, 1);
        normal_mode <= 1'b1;
        req(0, 0, `BFS_ADDR_TRIM_ONE, 0, 0, 0, 1);
        `CHK("trim_opcode", 3'h0, trim_opcode)
        for (int i = 0; i < 4; i++) begin
            req(1, 0, `BFS_ADDR_TRIM_ONE, wd(i == 3 ? 3'h7 : 3'(i + 1), f1),
                0, 0, 1);
        end
        req(1, 0, `BFS_ADDR_TRIM_ONE, wd(3'h4, f1), 1, 0, 1);
        `CHK("trim_fields_one", 16'h0, trim_fields_one)
        req(1, 0, `BFS_ADDR_TRIM_ONE, wd(3'h4, f1), 0, 0, 0);
        `CHK("trim_fields_one", f1, trim_fields_one)
        `CHK("trim_opcode", 3'h4, trim_opcode)
        req(0, 0, `BFS_ADDR_TRIM_ONE, 0, 0, par({3'h4, f1, 5'h0}), 0);
        req(1, 0, `BFS_ADDR_TRIM_TWO, wd(3'h4, f2), 0, 0, 0);
        req(0, 0, `BFS_ADDR_TRIM_TWO, 0, 0, par({3'h4, f2, 5'h0}), 0);
        req(1, 0, `BFS_ADDR_STATUS, 24'h40, 0, 0, 1);
        req(0, 0, 8'h20, 0, 0, 0, 1);
        req(1, 0, `BFS_ADDR_TRIM_TWO, wd(3'h4, f2 | 16'h1), 0, 0, 0);
        `CHK("trim_done", 1'b1, trim_fields_two[0])
        req(0, 0, `BFS_ADDR_TRIM_ONE, 0, 0, 0, 1);
        req(1, 0, `BFS_ADDR_TRIM_ONE, wd(3'h4, ~f1), 0, 0, 1);
        `CHK("trim_fields_one", f1, trim_fields_one)
        $display("test trimming done");
        // Disabled boost gates pin fault, low output and overvoltage
        wait_allow(1'b1, 5);
        st(0, 24'h0);
        boost_disable <= 1'b1;
        out_pin_bad_raw <= 1'b1;
        {pgood_n_raw, ovp_raw} <= 2'h3;
        repeat (6) @(posedge clk);
        st(1, 24'h0);
        boost_disable <= 1'b0;
        ovp_raw <= 1'b0;
        wait_allow(1'b0, 8);
        `CHK("phase_sync_en", 1'b0, phase_sync_en)
        `CHK("comp_pull_low", 1'b0, comp_pull_low)
        out_pin_bad_raw <= 1'b0;
        repeat (AUTO + 10) @(posedge clk);
        `CHK("boost_allow", 1'b0, boost_allow)
        st(1, 24'h140);
        wait_allow(1'b1, 6);
        `CHK("phase_sync_en", 1'b1, phase_sync_en)
        pgood_n_raw <= 1'b0;
        // Fallback mode restarts twice without any host command
        fallback_mode <= 1'b1;
        repeat (2) begin
            out_pin_bad_raw <= 1'b1;
            wait_allow(1'b0, 8);
            `CHK("comp_pull_low", 1'b1, comp_pull_low)
            `CHK("phase_sync_en", 1'b0, phase_sync_en)
            out_pin_bad_raw <= 1'b0;
            wait_allow(1'b1, AUTO + 10);
        end
        fallback_mode <= 1'b0;
        st(0, 24'h0);
        $display("test pin fault done");
        // Short overcurrent burst drops, a held one latches
        cyc(2, 1, 1, 1);
        cyc(2, 0, 1, 5);
        repeat (FILT + 10) @(posedge clk);
        st(0, 24'h0);
        cyc(1, 1, 1, 16);
        cyc(1, 0, 1, 5);
        st(1, 24'h8);
        st(0, 24'h0);
        // Peak timeout needs ten cycles both ways
        cyc(2, 0, 0, 8);
        st(0, 24'h0);
        cyc(2, 0, 0, 3);
        st(1, 24'h4);
        cyc(2, 0, 1, 8);
        st(0, 24'h4);
        cyc(2, 0, 1, 3);
        st(0, 24'h0);
        $display("test phase monitor done");
        repeat (4) @(posedge clk);
        `CHK("notes_left", 0, notes.size())
        summarize();
    end
endmodule : bfs_regs_tb
